// *** src/hpsb_slot_breaker.sv ***
// Behaviour
// RULE1: main overcurrent longer than breaker delay trips both main rails, standby untouched
// RULE2: fast-trip level on a main rail switches main rails off at once
// RULE3: supply undervoltage trips breaker only while main rails enabled
// RULE4: standby rail has no fast trip; trips only when delay expires
// RULE5: regulation during start-up starts the breaker delay timer
// RULE6: regulate inrush until rail reaches power-ok threshold, then set flag
// RULE7: after main fault, main enable must go high, low, high to re-enable
// RULE8: after standby fault, standby enable toggles likewise; both if both faulted
// RULE9: every trip raises the matching fault and shared interrupt together
// RULE10: interrupt released only by falling edge of main or standby enable
// RULE11: standby rail follows standby enable only, regardless of main undervoltage; code also needs card latch closed
// RULE12: controller should drop main enables before main supplies drop
// RULE13: switched-off outputs get discharge path connected
// RULE14: main rails start on main enable rise with card latch closed
// RULE15: reset clears all fault and status flags
// RULE16: tripped state stays latched until matching enable toggle
`timescale 1ns/100ps
`default_nettype none
module hpsb_slot_breaker #(
  parameter int unsigned DELAY_CYC = hpsb_pkg::BREAKER_DELAY_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // enables from the controlling party (pins)
  input wire logic main_enable,
  input wire logic standby_rail_enable,
  input wire logic card_latch_closed_n,
  // analog indications (pins)
  input wire logic main_over_limit,
  input wire logic main_fast_trip,
  input wire logic main_supply_uv,
  input wire logic standby_over_limit,
  input wire logic rail12_power_ok,
  input wire logic rail3_power_ok,
  // rail controls
  output logic rail12_gate_drive,
  output logic rail3_gate_drive,
  output logic main_regulate,
  output logic standby_rail_out,
  output logic main_discharge,
  output logic standby_discharge,
  // status
  output logic rail12_ok_flag,
  output logic rail3_ok_flag,
  output logic main_fault,
  output logic standby_fault,
  output logic irq
);

  localparam int NIN = 9;
  localparam logic [hpsb_pkg::DELAY_W-1:0] DLY = hpsb_pkg::DELAY_W'(DELAY_CYC);

  ////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change accepted once stages 2 and 3 agree
  logic [NIN-1:0] pin_raw, s1_r, s2_r, s3_r, clean_r, clean_nxt;
  assign pin_raw = {main_enable, standby_rail_enable, ~card_latch_closed_n, main_over_limit,
    main_fast_trip, main_supply_uv, standby_over_limit, rail12_power_ok, rail3_power_ok};

  always_comb begin
    clean_nxt = clean_r;
    for (int i = 0; i < NIN; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        clean_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      clean_r <= '0;
    end else if (clk_en) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      clean_r <= clean_nxt;
    end
  end

  logic en_m, en_s, latch_ok, oc_m, fast_m, uv_m, oc_s, pg12, pg3;
  assign {en_m, en_s, latch_ok, oc_m, fast_m, uv_m, oc_s, pg12, pg3} = clean_r;

  ////////////////////////////////////////////////////////////////
  // edge detection on the clean enables
  logic en_m_r, en_s_r;
  logic m_rise, m_fall, s_rise, s_fall;
  assign m_rise = en_m & ~en_m_r;
  assign m_fall = ~en_m & en_m_r;
  assign s_rise = en_s & ~en_s_r;
  assign s_fall = ~en_s & en_s_r;

  ////////////////////////////////////////////////////////////////
  // breaker state, delay timers and latched flags
  hpsb_pkg::hpsb_main_e mst_r, mst_nxt;
  hpsb_pkg::hpsb_aux_e ast_r, ast_nxt;
  logic [hpsb_pkg::DELAY_W-1:0] mcnt_r, mcnt_nxt, acnt_r, acnt_nxt;
  logic mflt_r, mflt_nxt, sflt_r, sflt_nxt, irq_r, irq_nxt;
  logic pg12_r, pg12_nxt, pg3_r, pg3_nxt, reg_r, reg_nxt;
  logic main_trip, aux_trip, main_live;

  assign main_live = (mst_r == hpsb_pkg::HPSB_RAMP) || (mst_r == hpsb_pkg::HPSB_ON);
  // one timer shared by slow overcurrent and regulation; fast trip bypasses it
  assign main_trip = main_live && (fast_m // RULE2
    || (oc_m && mcnt_r >= DLY - 1'b1) // RULE1 RULE5
    || uv_m); // RULE3 RULE12
  assign aux_trip = (ast_r == hpsb_pkg::HPSB_AON) && oc_s && acnt_r >= DLY - 1'b1; // RULE4

  always_comb begin
    mst_nxt = mst_r;
    ast_nxt = ast_r;
    mcnt_nxt = (main_live && oc_m) ? mcnt_r + 1'b1 : '0; // RULE5
    acnt_nxt = (ast_r == hpsb_pkg::HPSB_AON && oc_s) ? acnt_r + 1'b1 : '0;
    mflt_nxt = mflt_r;
    sflt_nxt = sflt_r;
    irq_nxt = irq_r;
    pg12_nxt = pg12_r;
    pg3_nxt = pg3_r;
    reg_nxt = 1'b0;
    case (mst_r)
      hpsb_pkg::HPSB_OFF: begin
        if (m_rise && latch_ok) begin // RULE14
          mst_nxt = hpsb_pkg::HPSB_RAMP;
        end
      end
      hpsb_pkg::HPSB_RAMP: begin
        reg_nxt = oc_m; // RULE5
        if (pg12) pg12_nxt = 1'b1; // RULE6
        if (pg3) pg3_nxt = 1'b1; // RULE6
        if (pg12_r && pg3_r) mst_nxt = hpsb_pkg::HPSB_ON;
      end
      hpsb_pkg::HPSB_ON: begin
        reg_nxt = oc_m;
      end
      hpsb_pkg::HPSB_TRIP: begin
        // held off until enable toggles high-low-high; clears on the rise
        if (m_rise && latch_ok) begin // RULE7 RULE16
          mst_nxt = hpsb_pkg::HPSB_RAMP;
          mflt_nxt = 1'b0;
        end
      end
      default: mst_nxt = hpsb_pkg::HPSB_OFF;
    endcase
    if (main_live && (!en_m || !latch_ok)) begin
      mst_nxt = hpsb_pkg::HPSB_OFF;
      reg_nxt = 1'b0;
    end
    if (mst_nxt == hpsb_pkg::HPSB_OFF || mst_nxt == hpsb_pkg::HPSB_TRIP) begin
      pg12_nxt = 1'b0;
      pg3_nxt = 1'b0;
    end
    case (ast_r)
      hpsb_pkg::HPSB_AOFF: begin
        if (en_s && latch_ok) ast_nxt = hpsb_pkg::HPSB_AON; // RULE11
      end
      hpsb_pkg::HPSB_AON: begin
        if (!en_s || !latch_ok) ast_nxt = hpsb_pkg::HPSB_AOFF;
      end
      hpsb_pkg::HPSB_ATRIP: begin
        if (s_rise && latch_ok) begin // RULE8 RULE16
          ast_nxt = hpsb_pkg::HPSB_AON;
          sflt_nxt = 1'b0;
        end
      end
      default: ast_nxt = hpsb_pkg::HPSB_AOFF;
    endcase
    // interrupt release on a falling enable; a trip in the same cycle wins
    if (m_fall || s_fall) irq_nxt = 1'b0; // RULE10
    if (main_trip) begin // RULE1 RULE9
      mst_nxt = hpsb_pkg::HPSB_TRIP;
      mflt_nxt = 1'b1;
      irq_nxt = 1'b1;
      reg_nxt = 1'b0;
      pg12_nxt = 1'b0;
      pg3_nxt = 1'b0;
    end
    if (aux_trip) begin // RULE4 RULE9
      ast_nxt = hpsb_pkg::HPSB_ATRIP;
      sflt_nxt = 1'b1;
      irq_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin // RULE15
      mst_r <= hpsb_pkg::HPSB_OFF;
      ast_r <= hpsb_pkg::HPSB_AOFF;
      mcnt_r <= '0;
      acnt_r <= '0;
      mflt_r <= hpsb_pkg::RESET_OFF;
      sflt_r <= hpsb_pkg::RESET_OFF;
      irq_r <= hpsb_pkg::RESET_OFF;
      pg12_r <= hpsb_pkg::RESET_OFF;
      pg3_r <= hpsb_pkg::RESET_OFF;
      reg_r <= hpsb_pkg::RESET_OFF;
      en_m_r <= 1'b0;
      en_s_r <= 1'b0;
    end else if (clk_en) begin
      mst_r <= mst_nxt;
      ast_r <= ast_nxt;
      mcnt_r <= mcnt_nxt;
      acnt_r <= acnt_nxt;
      mflt_r <= mflt_nxt;
      sflt_r <= sflt_nxt;
      irq_r <= irq_nxt;
      pg12_r <= pg12_nxt;
      pg3_r <= pg3_nxt;
      reg_r <= reg_nxt;
      en_m_r <= en_m;
      en_s_r <= en_s;
    end
  end

  ////////////////////////////////////////////////////////////////
  // output registers: gate drives follow next state, discharge has its own flop
  // so every pin leaves a register with no inverter glitch behind it
  logic m_on_r, m_on_nxt, s_on_r, s_on_nxt;
  logic m_dis_r, m_dis_nxt, s_dis_r, s_dis_nxt;
  always_comb begin
    m_on_nxt = (mst_nxt == hpsb_pkg::HPSB_RAMP) || (mst_nxt == hpsb_pkg::HPSB_ON);
    s_on_nxt = ast_nxt == hpsb_pkg::HPSB_AON; // RULE11
    m_dis_nxt = ~m_on_nxt; // RULE13
    s_dis_nxt = ~s_on_nxt; // RULE13
  end

  // discharge paths are connected while in reset, rails off
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      m_on_r <= hpsb_pkg::RESET_OFF;
      s_on_r <= hpsb_pkg::RESET_OFF;
      m_dis_r <= ~hpsb_pkg::RESET_OFF;
      s_dis_r <= ~hpsb_pkg::RESET_OFF;
    end else if (clk_en) begin
      m_on_r <= m_on_nxt;
      s_on_r <= s_on_nxt;
      m_dis_r <= m_dis_nxt;
      s_dis_r <= s_dis_nxt;
    end
  end

  assign rail12_gate_drive = m_on_r;
  assign rail3_gate_drive = m_on_r;
  assign main_discharge = m_dis_r; // RULE13
  assign standby_rail_out = s_on_r;
  assign standby_discharge = s_dis_r; // RULE13
  assign main_regulate = reg_r;
  assign rail12_ok_flag = pg12_r;
  assign rail3_ok_flag = pg3_r;
  assign main_fault = mflt_r;
  assign standby_fault = sflt_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////
  // checks
  fast_trip_off_a: assert property (@(posedge clock) disable iff (!nrst) // RULE2
    clk_en && main_live && fast_m |=> !m_on_r && mflt_r)
    else $error("fast trip did not switch main rails off");
  trip_irq_pair_a: assert property (@(posedge clock) disable iff (!nrst) // RULE9
    clk_en && main_trip |=> mflt_r && irq_r)
    else $error("trip without fault and interrupt");
  uv_off_ignore_a: assert property (@(posedge clock) disable iff (!nrst) // RULE3
    clk_en && !main_live && uv_m && !mflt_r |=> !mflt_r)
    else $error("undervoltage tripped a switched-off slot");
  irq_release_a: assert property (@(posedge clock) disable iff (!nrst) // RULE10
    clk_en && irq_r && !m_fall && !s_fall |=> irq_r)
    else $error("interrupt released without enable fall");
  trip_latched_a: assert property (@(posedge clock) disable iff (!nrst) // RULE16
    clk_en && mst_r == hpsb_pkg::HPSB_TRIP && !m_rise |=> mst_r == hpsb_pkg::HPSB_TRIP)
    else $error("main trip released without enable rise");
  aux_no_fast_a: assert property (@(posedge clock) disable iff (!nrst) // RULE4
    clk_en && $rose(sflt_r) |-> $past(acnt_r) >= DLY - 1'b1)
    else $error("standby tripped before delay expired");
  start_latch_a: assert property (@(posedge clock) disable iff (!nrst) // RULE14
    clk_en && mst_r == hpsb_pkg::HPSB_OFF && !latch_ok |=> mst_r == hpsb_pkg::HPSB_OFF)
    else $error("main start without card latch");
  discharge_inv_a: assert property (@(posedge clock) disable iff (!nrst) // RULE13
    clk_en && !main_live |-> main_discharge)
    else $error("discharge not applied to off slot");
endmodule
`default_nettype wire

// *** common/hpsb_pkg.sv ***
`default_nettype none
package hpsb_pkg;
  // breaker delay default: filter time in microseconds
  localparam int unsigned BREAKER_DELAY_US = 40000;
  localparam int unsigned CLOCK_MHZ = 40;
  // delay in cycles is microseconds times clock MHz, an exact product of 1600000
  localparam int unsigned BREAKER_DELAY_CYC = BREAKER_DELAY_US * CLOCK_MHZ;
  localparam int unsigned DELAY_W = 24;
  // reset values
  localparam logic RESET_OFF = 1'b0;
  // slot main-rail states
  typedef enum logic [1:0] {
    HPSB_OFF,
    HPSB_RAMP,
    HPSB_ON,
    HPSB_TRIP
  } hpsb_main_e;
  typedef enum logic [1:0] {
    HPSB_AOFF,
    HPSB_AON,
    HPSB_ATRIP
  } hpsb_aux_e;
endpackage
`default_nettype wire

// *** tb/hpsb_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module hpsb_host_model (
  // clock
  input wire logic clock,
  // wishes from the bench
  input wire logic want_main,
  input wire logic want_stby,
  // enable pins toward the slot
  output logic main_enable,
  output logic standby_rail_enable
);
  ////////////////////////////////////////////////////////////////
  // single driver per pin; the slot is held in reset until the first copy lands
  // pins move only after the falling edge, so the slot sees clean setup
  // recovery is a high-low-high sequence of wishes, never a pulse here
  always @(negedge clock) begin
    main_enable <= want_main;
    standby_rail_enable <= want_stby;
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  localparam int unsigned DLY = 20;
  logic clock, nrst, want_main, want_stby, latch_n, over, fast, uv, sover, p12, p3, ce;
  wire logic men, sen, g12, g3, rg, sout, mdis, sdis, f12, f3, mf, sf, irq;
  int fails = 0;
  int comparisons = 0;
  // rows: main, standby, latch_n, uv | gate, standby out, main fault
  logic [6:0] rows [5] = '{7'h44, 7'h50, 7'h22, 7'h2a, 7'h66};
  ////////////////////////////////////////////////////////////////
  hpsb_host_model hpsb_host_model_inst (.clock(clock), .want_main(want_main),
    .want_stby(want_stby), .main_enable(men), .standby_rail_enable(sen));
  hpsb_slot_breaker #(.DELAY_CYC(DLY)) hpsb_slot_breaker_inst (.clock(clock),
    .nrst(nrst), .clk_en(ce), .main_enable(men), .standby_rail_enable(sen),
    .card_latch_closed_n(latch_n), .main_over_limit(over), .main_fast_trip(fast),
    .main_supply_uv(uv), .standby_over_limit(sover), .rail12_power_ok(p12),
    .rail3_power_ok(p3), .rail12_gate_drive(g12), .rail3_gate_drive(g3),
    .main_regulate(rg), .standby_rail_out(sout), .main_discharge(mdis),
    .standby_discharge(sdis), .rail12_ok_flag(f12), .rail3_ok_flag(f3),
    .main_fault(mf), .standby_fault(sf), .irq(irq));
  ////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // verdict and end of run, shared by the watchdog
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // inputs go quiet, reset held two cycles
  task automatic do_reset();
    {want_main, want_stby, over, fast, uv, sover, p12, p3} = 8'h00;
    latch_n = 1'b0;
    ce = 1'b1;
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
  endtask
  // model lag plus four sync edges plus the register, with margin
  task automatic settle();
    repeat (7) @(negedge clock);
  endtask
  // cuts a hang short; whole run is a few hundred cycles
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    results();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    `CHK({g12, g3, sout, rg, mf, sf, irq, f12, f3}, 9'h000)
    `CHK({mdis, sdis}, 2'h3)
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      do_reset();
      {want_main, want_stby, latch_n, uv} = rows[i][6:3];
      settle();
      `CHK({g12, sout, mf}, rows[i][2:0])
      `CHK(mdis, ~rows[i][2])
    end
    $display("test table done");
    // fast trip, latch, then recovery by toggling the enable
    do_reset();
    want_main = 1'b1;
    {p12, p3} = 2'h3;
    settle();
    `CHK({g12, g3, f12, f3}, 4'hf)
    fast = 1'b1;
    settle();
    `CHK({g12, g3, mf, irq, mdis}, 5'h07)
    fast = 1'b0;
    settle();
    `CHK({g12, mf, irq}, 3'h3)
    want_main = 1'b0;
    settle();
    `CHK({irq, mf}, 2'h1)
    want_main = 1'b1;
    settle();
    `CHK({g12, mf}, 2'h2)
    $display("test fast trip done");
    // slow overcurrent must wait out the delay; standby stays up
    do_reset();
    {want_main, want_stby} = 2'h3;
    settle();
    over = 1'b1;
    repeat (10) @(negedge clock);
    `CHK({g12, rg, mf}, 3'h6)
    // trip lands DLY plus four sync edges after the pin moves; one edge early is clean
    repeat (DLY - 7) @(negedge clock);
    `CHK(mf, 1'b0)
    @(negedge clock);
    `CHK({g12, mf, irq, sout}, 4'h7)
    over = 1'b0;
    uv = 1'b1;
    $display("test breaker delay done");
    // reset in mid-run wipes the latched trip
    do_reset();
    `CHK({g12, rg, mf, irq, f12, mdis}, 6'h01)
    $display("test mid reset done");
    // brown-out while on trips the main side, standby survives
    do_reset();
    {want_main, want_stby} = 2'h3;
    settle();
    uv = 1'b1;
    settle();
    `CHK({g12, mf, irq, sout}, 4'h7)
    $display("test undervoltage done");
    // standby overcurrent: no fast path, trips on delay only
    do_reset();
    {want_main, want_stby} = 2'h3;
    settle();
    sover = 1'b1;
    repeat (10) @(negedge clock);
    `CHK({sout, sf}, 2'h2)
    repeat (DLY - 7) @(negedge clock);
    `CHK(sf, 1'b0)
    @(negedge clock);
    `CHK({sout, sf, irq, g12}, 4'h7)
    sover = 1'b0;
    want_stby = 1'b0;
    settle();
    `CHK({irq, sf, sdis}, 3'h3)
    want_stby = 1'b1;
    settle();
    `CHK({sout, sf}, 2'h2)
    $display("test standby done");
    // clock enable low freezes everything, enable drop only acts once it returns
    ce = 1'b0;
    want_stby = 1'b0;
    settle();
    `CHK({sout, sdis}, 2'h2)
    ce = 1'b1;
    settle();
    `CHK({sout, sdis}, 2'h1)
    $display("test freeze done");
    results();
  end
endmodule
`default_nettype wire
